//--- common/fifo_pkg.sv
package fifo_pkg;

  localparam int          DATA_W          = 18;
  localparam int          ADDR_W          = 13;
  localparam int          PTR_W           = 14;
  localparam logic [13:0] DEPTH           = 14'h2000;
  localparam logic [13:0] HALF_LEVEL      = 14'h1000;
  localparam logic [12:0] LAST_LOC        = 13'h1FFF;
  localparam logic [13:0] DEF_OFFSET      = 14'h007F;

  localparam logic [11:0] CTRL_ADDR       = 12'h000;
  localparam logic [11:0] OFFSET_ADDR     = 12'h004;
  localparam logic [11:0] STATUS_ADDR     = 12'h008;

  localparam int          CTRL_ASYNC_BIT  = 0;
  localparam int          CTRL_EXPAND_BIT = 1;
  localparam logic [1:0]  CTRL_RST        = 2'h0;
  localparam int          EMPTY_OFF_LSB   = 0;
  localparam int          FULL_OFF_LSB    = 16;
  localparam int          STAT_RTOK_BIT   = 5;
  localparam int          STAT_WTOK_BIT   = 6;
  localparam int          STAT_COUNT_LSB  = 16;

  localparam int          PIN_W           = 27;

  typedef struct packed {
    logic half_full_flag_n;
    logic almost_full_flag_n;
    logic full_flag_n;
    logic almost_empty_flag_n;
    logic empty_flag_n;
  } fifo_flags_s;

  localparam fifo_flags_s FLAGS_RST = 5'h1C;

  typedef struct packed {
    logic                write_clock;
    logic                read_clock;
    logic                write_en_n;
    logic                read_en_n;
    logic                out_en_n;
    logic                buffer_reset_n;
    logic                replay_pulse;
    logic                write_cascade_in_n;
    logic                read_cascade_in_n;
    logic [DATA_W-1:0]   data;
  } pins_s;

endpackage

//--- rtl/sync_fifo_flags.sv
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ns
module sync_fifo_flags (
  input  wire logic                        I_CLOCK,
  input  wire logic                        I_RSTN,
  input  wire logic                        I_WRITE_CLOCK,
  input  wire logic                        I_READ_CLOCK,
  input  wire logic                        I_WRITE_EN_N,
  input  wire logic                        I_READ_EN_N,
  input  wire logic                        I_OUT_EN_N,
  input  wire logic                        I_BUFFER_RESET_N,
  input  wire logic                        I_REPLAY_PULSE,
  input  wire logic                        I_WRITE_CASCADE_IN_N,
  input  wire logic                        I_READ_CASCADE_IN_N,
  input  wire logic                        I_FIRST_DEVICE_SELECT,
  input  wire logic [fifo_pkg::DATA_W-1:0] I_DATA,
  output logic      [fifo_pkg::DATA_W-1:0] O_DATA,
  output logic                             O_DATA_OE,
  output fifo_pkg::fifo_flags_s            O_FLAGS,
  output logic                             O_WRITE_CASCADE_OUT_N,
  output logic                             O_READ_CASCADE_OUT_N,
  input  wire logic                        I_PSEL,
  input  wire logic                        I_PENABLE,
  input  wire logic                        I_PWRITE,
  input  wire logic [11:0]                 I_PADDR,
  input  wire logic [31:0]                 I_PWDATA,
  output logic      [31:0]                 O_PRDATA,
  output logic                             O_PREADY,
  output logic                             O_PSLVERR
);
  import fifo_pkg::*;

  pins_s             pins_in;
  pins_s             meta_reg;
  pins_s             sync_reg;
  pins_s             prev_reg;
  logic              fl_meta_reg;
  logic              fl_sync_reg;
  logic [DATA_W-1:0] mem [0:(1 << ADDR_W)-1];
  logic [PTR_W-1:0]  wptr_reg;
  logic [PTR_W-1:0]  rptr_reg;
  logic [PTR_W-1:0]  count;
  logic [PTR_W-1:0]  wcount;
  logic [PTR_W-1:0]  rcount;
  logic              wr_edge;
  logic              rd_edge;
  logic              buf_rst;
  logic              wr_ok;
  logic              rd_ok;
  logic              wtok_reg;
  logic              rtok_reg;
  logic [1:0]        ctrl_reg;
  logic [13:0]       empty_off_reg;
  logic [13:0]       full_off_reg;
  logic              async_mode;
  logic              expand;
  logic              ae_level_n;
  logic              af_level_n;
  logic              apb_wr;
  logic [31:0]       rdata_next;
  logic              addr_ok;

  assign pins_in = '{write_clock:        I_WRITE_CLOCK,
                     read_clock:         I_READ_CLOCK,
                     write_en_n:         I_WRITE_EN_N,
                     read_en_n:          I_READ_EN_N,
                     out_en_n:           I_OUT_EN_N,
                     buffer_reset_n:     I_BUFFER_RESET_N,
                     replay_pulse:       I_REPLAY_PULSE,
                     write_cascade_in_n: I_WRITE_CASCADE_IN_N,
                     read_cascade_in_n:  I_READ_CASCADE_IN_N,
                     data:               I_DATA};

  // Two-stage synchronisers; a third stage gives the pre-edge sample so
  // data and enables are taken as they stood just before a clock edge.
  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN) begin
      meta_reg    <= '0;
      sync_reg    <= '0;
      prev_reg    <= '0;
      fl_meta_reg <= 1'b0;
      fl_sync_reg <= 1'b0;
    end else begin
      meta_reg    <= pins_in;
      sync_reg    <= meta_reg;
      prev_reg    <= sync_reg;
      fl_meta_reg <= I_FIRST_DEVICE_SELECT;
      fl_sync_reg <= fl_meta_reg;
    end
  end

  assign wr_edge    = sync_reg.write_clock & ~prev_reg.write_clock;
  assign rd_edge    = sync_reg.read_clock & ~prev_reg.read_clock;
  // Clocks may keep toggling; reset is a level, so edges during it are harmless
  assign buf_rst    = ~sync_reg.buffer_reset_n;
  assign async_mode = ctrl_reg[CTRL_ASYNC_BIT];
  assign expand     = ctrl_reg[CTRL_EXPAND_BIT];
  assign count      = wptr_reg - rptr_reg;
  // Fill as each side will see it after this edge. The other side's move in
  // the same system clock is left out, so full and empty only err towards
  // asserted and can never let one word too many through.
  assign wcount     = count + {{(PTR_W-1){1'b0}}, wr_ok};
  assign rcount     = count - {{(PTR_W-1){1'b0}}, rd_ok};

  // Acceptance is gated by the registered flags, so a request seen while
  // a flag still shows full or empty is dropped, never queued.
  assign wr_ok = wr_edge && !prev_reg.write_en_n && O_FLAGS.full_flag_n
                 && (!expand || wtok_reg);
  assign rd_ok = rd_edge && !prev_reg.read_en_n && O_FLAGS.empty_flag_n
                 && (!expand || rtok_reg);

  always_ff @(posedge I_CLOCK) begin
    if (wr_ok) begin
      mem[wptr_reg[ADDR_W-1:0]] <= prev_reg.data;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN || buf_rst) begin
      wptr_reg <= '0;
    end else if (wr_ok) begin
      wptr_reg <= wptr_reg + 1'b1;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN || buf_rst) begin
      rptr_reg <= '0;
    end else if (sync_reg.replay_pulse && !expand) begin
      rptr_reg <= '0;
    end else if (rd_ok) begin
      rptr_reg <= rptr_reg + 1'b1;
    end
  end

  // Output register only loads on an accepted read: holds last word when empty
  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN || buf_rst) begin
      O_DATA <= '0;
    end else if (rd_ok) begin
      O_DATA <= mem[rptr_reg[ADDR_W-1:0]];
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN) begin
      O_DATA_OE <= 1'b0;
    end else begin
      O_DATA_OE <= !sync_reg.out_en_n && (!expand || rtok_reg);
    end
  end

  // Depth-expansion tokens: every device holds both after I_RSTN; a buffer reset gives both only where first-device select is low
  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN || buf_rst) begin
      wtok_reg <= ~fl_sync_reg;
    end else if (wr_ok && wptr_reg[ADDR_W-1:0] == LAST_LOC) begin
      wtok_reg <= 1'b0;
    end else if (wr_edge && !prev_reg.write_cascade_in_n) begin
      wtok_reg <= 1'b1;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN || buf_rst) begin
      rtok_reg <= ~fl_sync_reg;
    end else if (rd_ok && rptr_reg[ADDR_W-1:0] == LAST_LOC) begin
      rtok_reg <= 1'b0;
    end else if (rd_edge && !prev_reg.read_cascade_in_n) begin
      rtok_reg <= 1'b1;
    end
  end

  // Cascade outs stay low for one write/read clock period
  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN || buf_rst) begin
      O_WRITE_CASCADE_OUT_N <= 1'b1;
    end else if (wr_edge) begin
      O_WRITE_CASCADE_OUT_N <= !(wr_ok && wptr_reg[ADDR_W-1:0] == LAST_LOC);
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN || buf_rst) begin
      O_READ_CASCADE_OUT_N <= 1'b1;
    end else if (rd_edge) begin
      O_READ_CASCADE_OUT_N <= !(rd_ok && rptr_reg[ADDR_W-1:0] == LAST_LOC);
    end
  end

  // Levels from the live pointer distance; the edge sampling below sees
  // the other side's pointer one system clock later, which is the skew.
  assign ae_level_n = (rcount > empty_off_reg);
  assign af_level_n = (wcount < DEPTH - full_off_reg);

  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN || buf_rst) begin
      O_FLAGS.empty_flag_n <= 1'b0;
    end else if (rd_edge) begin
      O_FLAGS.empty_flag_n <= (rcount != '0);
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN || buf_rst) begin
      O_FLAGS.full_flag_n <= FLAGS_RST.full_flag_n;
    end else if (wr_edge) begin
      O_FLAGS.full_flag_n <= (wcount != DEPTH);
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN || buf_rst) begin
      O_FLAGS.almost_empty_flag_n <= FLAGS_RST.almost_empty_flag_n;
    end else if (async_mode || rd_edge) begin
      O_FLAGS.almost_empty_flag_n <= ae_level_n;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN || buf_rst) begin
      O_FLAGS.almost_full_flag_n <= FLAGS_RST.almost_full_flag_n;
    end else if (async_mode || wr_edge) begin
      O_FLAGS.almost_full_flag_n <= af_level_n;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN || buf_rst) begin
      O_FLAGS.half_full_flag_n <= FLAGS_RST.half_full_flag_n;
    end else begin
      O_FLAGS.half_full_flag_n <= (count <= HALF_LEVEL);
    end
  end

  // APB slave: zero wait states, pready registered in the setup cycle
  assign addr_ok = (I_PADDR == CTRL_ADDR) || (I_PADDR == OFFSET_ADDR)
                   || (I_PADDR == STATUS_ADDR);
  assign apb_wr  = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && addr_ok;

  always_comb begin
    rdata_next = '0;
    if (I_PADDR == CTRL_ADDR) begin
      rdata_next[1:0] = ctrl_reg;
    end else if (I_PADDR == OFFSET_ADDR) begin
      rdata_next[EMPTY_OFF_LSB +: 14] = empty_off_reg;
      rdata_next[FULL_OFF_LSB +: 14]  = full_off_reg;
    end else if (I_PADDR == STATUS_ADDR) begin
      rdata_next[4:0]                  = O_FLAGS;
      rdata_next[STAT_RTOK_BIT]        = rtok_reg;
      rdata_next[STAT_WTOK_BIT]        = wtok_reg;
      rdata_next[STAT_COUNT_LSB +: 14] = count;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN) begin
      O_PREADY  <= 1'b0;
      O_PRDATA  <= '0;
      O_PSLVERR <= 1'b0;
    end else begin
      O_PREADY  <= I_PSEL && !I_PENABLE;
      O_PRDATA  <= (I_PSEL && !I_PENABLE && !I_PWRITE) ? rdata_next : 32'h0;
      O_PSLVERR <= I_PSEL && !I_PENABLE && !addr_ok;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN) begin
      ctrl_reg <= CTRL_RST;
    end else if (apb_wr && I_PADDR == CTRL_ADDR) begin
      ctrl_reg <= I_PWDATA[1:0];
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN) begin
      empty_off_reg <= DEF_OFFSET;
      full_off_reg  <= DEF_OFFSET;
    end else if (apb_wr && I_PADDR == OFFSET_ADDR) begin
      empty_off_reg <= I_PWDATA[EMPTY_OFF_LSB +: 14];
      full_off_reg  <= I_PWDATA[FULL_OFF_LSB +: 14];
    end
  end

endmodule

//--- verification/link_peer.sv
`timescale 1ns/1ns
module link_peer (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_go,
  input  wire logic [13:0] i_wr_n,
  input  wire logic [13:0] i_rd_n,
  output logic             o_wclk,
  output logic             o_rclk,
  output logic             o_wen_n,
  output logic             o_ren_n,
  output logic [17:0]      o_data,
  output logic             o_busy
);
  // Link clocks run free, through reset too; read phase offset avoids coincident edges
  logic [2:0]  wph_reg = 3'h0;
  logic [2:0]  rph_reg = 3'h3;
  logic [13:0] wl_reg;
  logic [13:0] rl_reg;
  logic [17:0] seq_reg;
  assign o_wclk = !wph_reg[2];
  assign o_rclk = !rph_reg[2];
  assign o_busy = (wl_reg != 14'h0) || (rl_reg != 14'h0) || !o_wen_n || !o_ren_n;
  always_ff @(posedge i_clk) begin
    wph_reg <= wph_reg + 3'h1;
    rph_reg <= rph_reg + 3'h1;
  end
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      wl_reg  <= 14'h0;
      rl_reg  <= 14'h0;
      seq_reg <= 18'h0;
      o_wen_n <= 1'b1;
      o_ren_n <= 1'b1;
      o_data  <= 18'h0;
    end else if (i_go) begin
      wl_reg <= i_wr_n;
      rl_reg <= i_rd_n;
    end else begin
      if (wph_reg == 3'h5) begin
        o_wen_n <= (wl_reg == 14'h0);
        // Idle data toggles so a stale word never looks valid
        o_data  <= (wl_reg == 14'h0) ? ~o_data : seq_reg;
        seq_reg <= seq_reg + {17'h0, (wl_reg != 14'h0)};
        wl_reg  <= wl_reg - {13'h0, (wl_reg != 14'h0)};
      end
      if (rph_reg == 3'h5) begin
        o_ren_n <= (rl_reg == 14'h0);
        rl_reg  <= rl_reg - {13'h0, (rl_reg != 14'h0)};
      end
    end
  end
endmodule

//--- verification/sync_fifo_flags_assertions.sv
`timescale 1ns/1ns
module sync_fifo_flags_assertions
  import fifo_pkg::*;
(
  input wire logic              I_CLOCK,
  input wire logic              I_RSTN,
  input wire logic              I_OUT_EN_N,
  input wire logic              I_BUFFER_RESET_N,
  input wire logic              I_PSEL,
  input wire logic              I_PENABLE,
  input wire logic [11:0]       I_PADDR,
  input wire logic [DATA_W-1:0] O_DATA,
  input wire logic              O_DATA_OE,
  input wire fifo_flags_s       O_FLAGS,
  input wire logic              O_WRITE_CASCADE_OUT_N,
  input wire logic [31:0]       O_PRDATA,
  input wire logic              O_PREADY,
  input wire logic              O_PSLVERR
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RSTN);
  reset_state_a:
    assert property ($rose(I_RSTN) |-> O_FLAGS == 5'h1C && O_DATA == 18'h0 && !O_DATA_OE)
    else $error("state after reset wrong");
  zero_wait_a:
    assert property (I_PSEL && !I_PENABLE |=> O_PREADY)
    else $error("ready missing in access cycle");
  ready_pulse_a:
    assert property (O_PREADY |=> !O_PREADY)
    else $error("ready held too long");
  bad_addr_a:
    assert property (I_PSEL && !I_PENABLE && I_PADDR > 12'h008 |=> O_PSLVERR && O_PRDATA == 32'h0)
    else $error("unmapped access not refused");
  output_off_a:
    assert property (I_OUT_EN_N [*5] |-> !O_DATA_OE)
    else $error("outputs driven while disabled");
  empty_set_a:
    assert property (!O_FLAGS.empty_flag_n |-> O_FLAGS == 5'h1C)
    else $error("flags inconsistent with empty");
  full_set_a:
    assert property (!O_FLAGS.full_flag_n |-> O_FLAGS == 5'h03)
    else $error("flags inconsistent with full");
  hold_empty_a:
    assert property (!O_FLAGS.empty_flag_n && I_BUFFER_RESET_N ##1 !O_FLAGS.empty_flag_n
                     |-> $stable(O_DATA))
    else $error("output word changed while empty");
  wr_cascade_a:
    assert property ($fell(O_WRITE_CASCADE_OUT_N)
                     |-> !O_WRITE_CASCADE_OUT_N [*8] ##1 O_WRITE_CASCADE_OUT_N)
    else $error("write cascade pulse length wrong");
  full_c: cover property (!O_FLAGS.full_flag_n);
  err_c: cover property (O_PREADY && O_PSLVERR);
  casc_c: cover property ($fell(O_WRITE_CASCADE_OUT_N));
endmodule
bind sync_fifo_flags sync_fifo_flags_assertions u_chk (
  .I_CLOCK(I_CLOCK), .I_RSTN(I_RSTN), .I_OUT_EN_N(I_OUT_EN_N),
  .I_BUFFER_RESET_N(I_BUFFER_RESET_N), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PADDR(I_PADDR), .O_DATA(O_DATA), .O_DATA_OE(O_DATA_OE), .O_FLAGS(O_FLAGS),
  .O_WRITE_CASCADE_OUT_N(O_WRITE_CASCADE_OUT_N), .O_PRDATA(O_PRDATA),
  .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR)
);

//--- verification/tb.sv
`timescale 1ns/1ns
module tb;
  import fifo_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        oe_n = 1'b0;
  logic        brst_n = 1'b1;
  logic        replay = 1'b0;
  logic        go = 1'b0;
  logic [13:0] wr_n = 14'h0;
  logic [13:0] rd_n = 14'h0;
  logic        wclk, rclk, wen_n, ren_n, busy, data_oe, pready, pslverr;
  logic [17:0] wdata;
  logic [17:0] q_data;
  logic [31:0] prdata;
  fifo_flags_s flags;
  int          mismatches = 0;
  int          n_checks = 0;
  always #10 clk = ~clk;
  link_peer u_peer (.i_clk(clk), .i_rstn(rstn), .i_go(go), .i_wr_n(wr_n), .i_rd_n(rd_n),
    .o_wclk(wclk), .o_rclk(rclk), .o_wen_n(wen_n), .o_ren_n(ren_n), .o_data(wdata),
    .o_busy(busy));
  sync_fifo_flags u_dut (.I_CLOCK(clk), .I_RSTN(rstn), .I_WRITE_CLOCK(wclk),
    .I_READ_CLOCK(rclk), .I_WRITE_EN_N(wen_n), .I_READ_EN_N(ren_n), .I_OUT_EN_N(oe_n),
    .I_BUFFER_RESET_N(brst_n), .I_REPLAY_PULSE(replay), .I_WRITE_CASCADE_IN_N(1'b1),
    .I_READ_CASCADE_IN_N(1'b1), .I_FIRST_DEVICE_SELECT(1'b0), .I_DATA(wdata),
    .O_DATA(q_data), .O_DATA_OE(data_oe), .O_FLAGS(flags), .O_WRITE_CASCADE_OUT_N(),
    .O_READ_CASCADE_OUT_N(), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int k;
    k = 0;
    // Idle edge first, so back-to-back calls never rewrite psel in one step
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // Ready and read data are taken as they stood at the rising edge
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      mismatches++;
      end_of_test();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // Waits for the link traffic, then three link periods for the flags to settle
  task automatic run(input logic [13:0] w, input logic [13:0] r);
    int k;
    k = 0;
    wr_n <= w;
    rd_n <= r;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    do begin
      @(negedge clk);
      k++;
    end while (busy !== 1'b0 && k < 70000);
    if (k >= 70000) begin
      mismatches++;
      end_of_test();
    end
    repeat (24) @(posedge clk);
  endtask
  task automatic stat(input logic [13:0] cnt, input logic [4:0] f);
    logic [31:0] q;
    logic        e;
    apb(1'b0, STATUS_ADDR, 32'h0, q, e);
    chk({18'h0, q[29:16]}, {18'h0, cnt});
    chk({27'h0, q[4:0]}, {27'h0, f});
    chk({27'h0, flags}, {27'h0, f});
  endtask
  task automatic t_reset();
    logic [31:0] q;
    logic        e;
    chk({27'h0, flags}, 32'h1C);
    chk({13'h0, q_data, data_oe}, 32'h1);
    apb(1'b0, CTRL_ADDR, 32'h0, q, e);
    chk(q, 32'h0);
    apb(1'b1, CTRL_ADDR, 32'h1, q, e);
    apb(1'b0, CTRL_ADDR, 32'h0, q, e);
    chk(q, 32'h1);
    apb(1'b1, CTRL_ADDR, 32'h0, q, e);
    apb(1'b0, OFFSET_ADDR, 32'h0, q, e);
    chk(q, 32'h007F007F);
    apb(1'b1, 12'h00C, 32'hFFFFFFFF, q, e);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, 12'h00C, 32'h0, q, e);
    chk({q[30:0], e}, 32'h1);
    $display("reset test done");
  endtask
  task automatic t_stream();
    run(14'h3, 14'h0);
    stat(14'h3, 5'h1D);
    run(14'h0, 14'h3);
    chk({14'h0, q_data}, 32'h2);
    stat(14'h0, 5'h1C);
    run(14'h0, 14'h2);
    chk({14'h0, q_data}, 32'h2);
    oe_n <= 1'b1;
    repeat (5) @(posedge clk);
    chk({31'h0, data_oe}, 32'h0);
    oe_n <= 1'b0;
    repeat (5) @(posedge clk);
    chk({31'h0, data_oe}, 32'h1);
    $display("stream test done");
  endtask
  task automatic t_almost_empty();
    logic [31:0] q;
    logic        e;
    apb(1'b1, OFFSET_ADDR, 32'h007F0002, q, e);
    run(14'h3, 14'h0);
    stat(14'h3, 5'h1F);
    run(14'h0, 14'h1);
    stat(14'h2, 5'h1D);
    run(14'h0, 14'h2);
    chk({14'h0, q_data}, 32'h5);
    $display("almost empty test done");
  endtask
  task automatic t_full();
    run(14'h1F80, 14'h0);
    stat(14'h1F80, 5'h0F);
    run(14'h1, 14'h0);
    stat(14'h1F81, 5'h07);
    run(14'h80, 14'h0);
    stat(14'h2000, 5'h03);
    run(14'h0, 14'h1);
    chk({14'h0, q_data}, 32'h6);
    stat(14'h1FFF, 5'h07);
    $display("full test done");
  endtask
  task automatic t_buffer_reset();
    brst_n <= 1'b0;
    repeat (4) @(posedge clk);
    brst_n <= 1'b1;
    repeat (8) @(posedge clk);
    stat(14'h0, 5'h1C);
    chk({14'h0, q_data}, 32'h0);
    run(14'h1, 14'h0);
    run(14'h0, 14'h1);
    chk({14'h0, q_data}, 32'h2007);
    $display("buffer reset test done");
  endtask
  task automatic t_replay();
    run(14'h2, 14'h0);
    run(14'h0, 14'h2);
    chk({14'h0, q_data}, 32'h2009);
    replay <= 1'b1;
    repeat (4) @(posedge clk);
    replay <= 1'b0;
    // Sync almost-empty needs a read edge, almost-full a write edge, after the replay before use
    repeat (16) @(posedge clk);
    stat(14'h3, 5'h1F);
    run(14'h0, 14'h1);
    chk({14'h0, q_data}, 32'h2007);
    stat(14'h2, 5'h1D);
    $display("replay test done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
    t_reset();
    t_stream();
    t_almost_empty();
    t_full();
    t_buffer_reset();
    t_replay();
    end_of_test();
  end
endmodule
